// >>> hdl/pmbus_pkg.sv
// Command codes, field layouts, limits and reset values of the telemetry block
`default_nettype none
package pmbus_pkg;
  // Command codes
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0] CMD_VOUT_SETPOINT = 8'h21;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_VIN_ON = 8'h35;
  localparam logic [7:0] CMD_VIN_OFF = 8'h36;
  localparam logic [7:0] CMD_TON_DELAY = 8'h60;
  localparam logic [7:0] CMD_TON_RISE = 8'h61;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_FAULT_STATUS = 8'h7a;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_FAULT_STATUS = 8'h7b;
  localparam logic [7:0] CMD_STATUS_CML = 8'h7e;
  localparam logic [7:0] CMD_READ_VIN = 8'h88;
  localparam logic [7:0] CMD_READ_VOUT = 8'h8b;
  localparam logic [7:0] CMD_READ_IOUT = 8'h8c;
  localparam logic [7:0] CMD_READ_TEMP = 8'h8d;
  localparam logic [7:0] CMD_VOUT_CAL_OFS = 8'hd0;
  localparam logic [7:0] CMD_VIN_CAL_OFS = 8'hd1;
  localparam logic [7:0] CMD_VIN_CAL_GAIN = 8'hd2;
  localparam logic [7:0] CMD_IOUT_CAL_OFS = 8'hd3;
  localparam logic [7:0] CMD_IOUT_CAL_GAIN = 8'hd4;
  // Fixed linear exponents, five-bit two's complement
  localparam logic [4:0] EXP_VIN = 5'h1d;
  localparam logic [4:0] EXP_TON = 5'h1f;
  localparam logic [4:0] EXP_TEMP = 5'h1e;
  localparam logic [4:0] EXP_IOUT = 5'h1c;
  localparam logic [7:0] VOUT_MODE_VAL = 8'h14;
  localparam int GAIN_SHIFT = 13;
  // Input thresholds: 32.000 V to 46.000 V, 0.125 V steps, 2 V gap
  localparam logic [10:0] VIN_MIN = 11'h100;
  localparam logic [10:0] VIN_MAX = 11'h170;
  localparam logic [10:0] VIN_HYST = 11'h010;
  // Turn-on timing in 0.5 ms steps
  localparam logic [10:0] TON_DELAY_MIN = 11'h014;
  localparam logic [10:0] TON_RISE_MIN = 11'h01e;
  localparam logic [10:0] TON_MAX = 11'h3e8;
  // Output setpoint and margins, millivolts scaled by 4096/1000
  localparam int VOUT_MIN_MV = 8100;
  localparam int VOUT_MAX_MV = 13200;
  localparam int MARGIN_MIN_MV = 5000;
  localparam logic [15:0] VOUT_SET_MIN =
    16'((VOUT_MIN_MV * 4096 + 999) / 1000);
  localparam logic [15:0] VOUT_SET_MAX = 16'((VOUT_MAX_MV * 4096) / 1000);
  localparam logic [15:0] MARGIN_MIN =
    16'((MARGIN_MIN_MV * 4096 + 999) / 1000);
  // Current blanking: 1.65 A in 62.5 mA counts, rounded up
  localparam int IOUT_BLANK_UA = 1650000;
  localparam int IOUT_LSB_UA = 62500;
  localparam logic [10:0] IOUT_BLANK =
    11'((IOUT_BLANK_UA + IOUT_LSB_UA - 1) / IOUT_LSB_UA);
  // Reset values
  localparam logic [7:0] OPERATION_RST = 8'h88;
  localparam logic [7:0] ON_OFF_RST = 8'h1f;
  localparam logic [15:0] VOUT_SET_RST = 16'hc000;
  localparam logic [15:0] MARGIN_HIGH_RST = 16'hc99a;
  localparam logic [15:0] MARGIN_LOW_RST = 16'hb666;
  localparam logic [15:0] VIN_ON_RST = {EXP_VIN, 11'h110};
  localparam logic [15:0] VIN_OFF_RST = {EXP_VIN, 11'h100};
  localparam logic [15:0] TON_DELAY_RST = {EXP_TON, 11'h014};
  localparam logic [15:0] TON_RISE_RST = {EXP_TON, 11'h01e};
  // Bit positions
  localparam int OP_ON = 7;
  localparam int SW_VOUT = 15, SW_IOUT = 14, SW_INPUT = 13, SW_PG_N = 11;
  localparam int SW_OFF = 6, SW_OV = 5, SW_OC = 4, SW_UV = 3;
  localparam int SW_TEMP = 2, SW_CML = 1;
  localparam int SV_OV = 7, SI_OC = 7, SI_WARN = 5;
  localparam int SC_CMD = 7, SC_DATA = 6;
  // Fault pin vector layout
  localparam int PIN_OV = 0, PIN_OC = 1, PIN_WARN = 2, PIN_UV = 3;
  localparam int PIN_TEMP = 4, PIN_PG = 5, PIN_W = 6;

  typedef enum logic [2:0] {
    MARGIN_OFF = 3'b001,
    MARGIN_LO = 3'b010,
    MARGIN_HI = 3'b100
  } margin_t;
endpackage : pmbus_pkg
`default_nettype wire

// >>> hdl/cal_if.sv
// Bundle between the telemetry block and one readback corrector
`timescale 1ns/1ps
`default_nettype none
interface cal_if;
  logic [10:0] raw;
  logic [15:0] gain;
  logic [10:0] offset;
  logic sink;
  logic [10:0] blank;
  logic [10:0] result;
  modport user (output raw, gain, offset, sink, blank, input result);
  modport corr (input raw, gain, offset, sink, blank, output result);
endinterface : cal_if
`default_nettype wire

// >>> hdl/readback_corrector.sv
// Gain and offset correction of one positive linear-format reading
`timescale 1ns/1ps
`default_nettype none
module readback_corrector (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Reading to correct
  cal_if.corr cal
);
  logic [26:0] prod;
  logic signed [16:0] sum;
  logic [10:0] nxt_res;
  logic [10:0] res_ff;

  localparam int GAIN_SHIFT_W = pmbus_pkg::GAIN_SHIFT;

  always_comb begin
    prod = 27'(cal.raw) * 27'(cal.gain);
    sum = $signed({3'b000, prod[26:GAIN_SHIFT_W]}) +
          $signed({{6{cal.offset[10]}}, cal.offset});
    // Mantissa top bit stays zero: only positive values are legal
    if (cal.sink || sum < 17'sd0) begin
      nxt_res = 11'h000;
    end else if (sum > 17'sd1023) begin
      nxt_res = 11'h3ff;
    end else begin
      nxt_res = {1'b0, sum[9:0]};
    end
    if (nxt_res < cal.blank) begin
      nxt_res = 11'h000;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_ff <= 11'h000;
    end else begin
      res_ff <= nxt_res;
    end
  end

  assign cal.result = res_ff;
endmodule : readback_corrector
`default_nettype wire

// >>> hdl/pmbus_telemetry_status.sv
// Command data, telemetry readback and status flags of the power module
//
// Behaviour
// - Input thresholds: exponent -3, positive mantissa
// - Turn-on delay 10 to 500 ms, 0.5 ms
// - Rise time 15 to 500 ms, 0.5 ms
// - Timing words: exponent -1, positive mantissa
// - Setpoint unsigned, 2^-12, 8.10 to 13.20 V
// - Store command commits thresholds, timing, setpoint, margins
// - Margin words unsigned with exponent -12
// - Operation bits 5:2 select margin off/low/high
// - Output voltage read: unsigned mantissa, exponent -12
// - Output voltage read adds factory signed offset
// - Input voltage read: exponent -3, positive mantissa
// - Input reading times gain over 8192 plus offset
// - Current read exponent -4, blanked below 1.65 A
// - Current reading times gain over 8192 plus offset
// - Sinking current reads as zero
// - Temperature read: exponent -2, signed mantissa
// - Summary high byte fault bits 15,14,13,11
// - Summary low byte bits 6 to 1
// - Output voltage status: overvoltage in bit 7
// - Current status: fault bit 7, warning bit 5
// - Unsupported status bits zero; all default zero except bit 11, set until power good passes the filter
// - Settings saved only on the store command
// - Operation bit 7 enables the output
`timescale 1ns/1ps
`default_nettype none
module pmbus_telemetry_status (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Decoded command port from the bus framer
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  // Converted readings, same clock
  input wire logic [15:0] vout_adc,
  input wire logic [10:0] vin_adc,
  input wire logic [10:0] iout_adc,
  input wire logic iout_sinking,
  input wire logic [10:0] temp_adc,
  // Factory calibration from non-volatile storage
  input wire logic [15:0] vout_readback_offset,
  input wire logic [15:0] vin_readback_offset,
  input wire logic [15:0] vin_readback_gain,
  input wire logic [15:0] current_readback_offset,
  input wire logic [15:0] current_readback_gain,
  // Fault pins from the power stage, asynchronous
  input wire logic vout_ov_pin,
  input wire logic iout_oc_pin,
  input wire logic iout_warn_pin,
  input wire logic vin_uv_pin,
  input wire logic temp_fault_pin,
  input wire logic power_good_pin,
  // Settings towards the power stage and storage
  output logic output_enable,
  output logic [15:0] vout_target,
  output logic [15:0] vout_setpoint,
  output logic [15:0] margin_high,
  output logic [15:0] margin_low,
  output logic [15:0] vin_on,
  output logic [15:0] vin_off,
  output logic [15:0] ton_delay,
  output logic [15:0] ton_rise,
  output logic store_all
);
  logic [7:0] op_ff;
  logic [7:0] onoff_ff;
  logic [15:0] vset_ff;
  logic [15:0] mhi_ff;
  logic [15:0] mlo_ff;
  logic [15:0] von_ff;
  logic [15:0] voff_ff;
  logic [15:0] tdly_ff;
  logic [15:0] trise_ff;
  logic [15:0] vtgt_ff;
  logic store_ff;
  logic [pmbus_pkg::PIN_W-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
  logic ov_ff, oc_ff, warn_ff, uv_ff, temp_ff;
  logic cml_cmd_ff, cml_data_ff;
  logic [15:0] vout_rd_ff;
  logic rsp_valid_ff;
  logic [15:0] rsp_data_ff;
  logic wr_known, wr_legal, rd_known;
  logic [15:0] rd_word;
  logic wr_take, clr, bad_cmd, bad_data;
  logic [15:0] status_word;
  logic [7:0] output_voltage_fault_status, output_current_fault_status, status_cml;
  logic signed [17:0] vout_sum;
  pmbus_pkg::margin_t margin_sel;

  cal_if vin_c ();
  cal_if iout_c ();

  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_range

  // Linear word with the fixed exponent and a bounded mantissa
  function automatic logic lin_ok(input logic [15:0] w,
                                  input logic [4:0] e,
                                  input logic [10:0] lo,
                                  input logic [10:0] hi);
    return (w[15:11] == e) && (w[10:0] >= lo) && (w[10:0] <= hi);
  endfunction : lin_ok

  // Readback correction for input voltage and output current
  assign vin_c.raw = vin_adc;
  assign vin_c.gain = vin_readback_gain;
  assign vin_c.offset = vin_readback_offset[10:0];
  assign vin_c.sink = 1'b0;
  assign vin_c.blank = 11'h000;
  assign iout_c.raw = iout_adc;
  assign iout_c.gain = current_readback_gain;
  assign iout_c.offset = current_readback_offset[10:0];
  assign iout_c.sink = iout_sinking;
  assign iout_c.blank = pmbus_pkg::IOUT_BLANK;

  readback_corrector u_vin_corr (
    .clk(clk),
    .sys_rst(sys_rst),
    .cal(vin_c.corr)
  );

  readback_corrector u_iout_corr (
    .clk(clk),
    .sys_rst(sys_rst),
    .cal(iout_c.corr)
  );

  // Write legality per command
  always_comb begin
    wr_known = 1'b1;
    wr_legal = 1'b0;
    unique case (cmd_code)
      pmbus_pkg::CMD_OPERATION: wr_legal = (cmd_wdata[5:4] != 2'b11);
      pmbus_pkg::CMD_ON_OFF_CONFIG: wr_legal = 1'b1;
      pmbus_pkg::CMD_CLEAR_FAULTS: wr_legal = 1'b1;
      pmbus_pkg::CMD_STORE_ALL: wr_legal = 1'b1;
      pmbus_pkg::CMD_VOUT_SETPOINT: begin
        wr_legal = in_range(cmd_wdata, pmbus_pkg::VOUT_SET_MIN,
                            pmbus_pkg::VOUT_SET_MAX);
      end
      pmbus_pkg::CMD_MARGIN_HIGH: begin
        wr_legal = in_range(cmd_wdata, pmbus_pkg::MARGIN_MIN,
                            pmbus_pkg::VOUT_SET_MAX) &&
                   (cmd_wdata > mlo_ff);
      end
      pmbus_pkg::CMD_MARGIN_LOW: begin
        wr_legal = in_range(cmd_wdata, pmbus_pkg::MARGIN_MIN,
                            pmbus_pkg::VOUT_SET_MAX) &&
                   (cmd_wdata < mhi_ff);
      end
      pmbus_pkg::CMD_VIN_ON: begin
        wr_legal = lin_ok(cmd_wdata, pmbus_pkg::EXP_VIN,
                          pmbus_pkg::VIN_MIN, pmbus_pkg::VIN_MAX) &&
                   (cmd_wdata[10:0] >=
                    voff_ff[10:0] + pmbus_pkg::VIN_HYST);
      end
      pmbus_pkg::CMD_VIN_OFF: begin
        wr_legal = lin_ok(cmd_wdata, pmbus_pkg::EXP_VIN,
                          pmbus_pkg::VIN_MIN, pmbus_pkg::VIN_MAX) &&
                   (cmd_wdata[10:0] + pmbus_pkg::VIN_HYST <=
                    von_ff[10:0]);
      end
      pmbus_pkg::CMD_TON_DELAY: begin
        wr_legal = lin_ok(cmd_wdata, pmbus_pkg::EXP_TON,
                          pmbus_pkg::TON_DELAY_MIN,
                          pmbus_pkg::TON_MAX);
      end
      pmbus_pkg::CMD_TON_RISE: begin
        wr_legal = lin_ok(cmd_wdata, pmbus_pkg::EXP_TON,
                          pmbus_pkg::TON_RISE_MIN,
                          pmbus_pkg::TON_MAX);
      end
      default: wr_known = 1'b0;
    endcase
  end

  // Status composition; unsupported bits are constant zero
  always_comb begin
    output_voltage_fault_status = 8'h00;
    output_voltage_fault_status[pmbus_pkg::SV_OV] = ov_ff;
    output_current_fault_status = 8'h00;
    output_current_fault_status[pmbus_pkg::SI_OC] = oc_ff;
    output_current_fault_status[pmbus_pkg::SI_WARN] = warn_ff;
    status_cml = 8'h00;
    status_cml[pmbus_pkg::SC_CMD] = cml_cmd_ff;
    status_cml[pmbus_pkg::SC_DATA] = cml_data_ff;
    status_word = 16'h0000;
    status_word[pmbus_pkg::SW_VOUT] = |output_voltage_fault_status;
    status_word[pmbus_pkg::SW_IOUT] = |output_current_fault_status;
    status_word[pmbus_pkg::SW_INPUT] = uv_ff;
    status_word[pmbus_pkg::SW_PG_N] = ~pin_ff[pmbus_pkg::PIN_PG];
    status_word[pmbus_pkg::SW_OFF] = ~op_ff[pmbus_pkg::OP_ON];
    status_word[pmbus_pkg::SW_OV] = ov_ff;
    status_word[pmbus_pkg::SW_OC] = oc_ff;
    status_word[pmbus_pkg::SW_UV] = uv_ff;
    status_word[pmbus_pkg::SW_TEMP] = temp_ff;
    status_word[pmbus_pkg::SW_CML] = |status_cml;
  end

  // Read multiplexer
  always_comb begin
    rd_known = 1'b1;
    rd_word = 16'h0000;
    unique case (cmd_code)
      pmbus_pkg::CMD_OPERATION: rd_word = {8'h00, op_ff};
      pmbus_pkg::CMD_ON_OFF_CONFIG: rd_word = {8'h00, onoff_ff};
      pmbus_pkg::CMD_VOUT_MODE: rd_word = {8'h00, pmbus_pkg::VOUT_MODE_VAL};
      pmbus_pkg::CMD_VOUT_SETPOINT: rd_word = vset_ff;
      pmbus_pkg::CMD_MARGIN_HIGH: rd_word = mhi_ff;
      pmbus_pkg::CMD_MARGIN_LOW: rd_word = mlo_ff;
      pmbus_pkg::CMD_VIN_ON: rd_word = von_ff;
      pmbus_pkg::CMD_VIN_OFF: rd_word = voff_ff;
      pmbus_pkg::CMD_TON_DELAY: rd_word = tdly_ff;
      pmbus_pkg::CMD_TON_RISE: rd_word = trise_ff;
      pmbus_pkg::CMD_STATUS_WORD: rd_word = status_word;
      pmbus_pkg::CMD_OUTPUT_VOLTAGE_FAULT_STATUS: rd_word = {8'h00, output_voltage_fault_status};
      pmbus_pkg::CMD_OUTPUT_CURRENT_FAULT_STATUS: rd_word = {8'h00, output_current_fault_status};
      pmbus_pkg::CMD_STATUS_CML: rd_word = {8'h00, status_cml};
      pmbus_pkg::CMD_READ_VOUT: rd_word = vout_rd_ff;
      pmbus_pkg::CMD_READ_VIN: begin
        rd_word = {pmbus_pkg::EXP_VIN, vin_c.result};
      end
      pmbus_pkg::CMD_READ_IOUT: begin
        rd_word = {pmbus_pkg::EXP_IOUT, iout_c.result};
      end
      pmbus_pkg::CMD_READ_TEMP: begin
        rd_word = {pmbus_pkg::EXP_TEMP, temp_adc};
      end
      pmbus_pkg::CMD_VOUT_CAL_OFS: rd_word = vout_readback_offset;
      pmbus_pkg::CMD_VIN_CAL_OFS: rd_word = vin_readback_offset;
      pmbus_pkg::CMD_VIN_CAL_GAIN: rd_word = vin_readback_gain;
      pmbus_pkg::CMD_IOUT_CAL_OFS: rd_word = current_readback_offset;
      pmbus_pkg::CMD_IOUT_CAL_GAIN: rd_word = current_readback_gain;
      default: rd_known = 1'b0;
    endcase
  end

  assign wr_take = cmd_valid && cmd_write && wr_known && wr_legal;
  assign clr = wr_take && (cmd_code == pmbus_pkg::CMD_CLEAR_FAULTS);
  assign bad_cmd = cmd_valid && (cmd_write ? !wr_known : !rd_known);
  assign bad_data = cmd_valid && cmd_write && wr_known && !wr_legal;

  // Operation: only on/off and margin bits are writable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_ff <= pmbus_pkg::OPERATION_RST;
      onoff_ff <= pmbus_pkg::ON_OFF_RST;
    end else if (wr_take) begin
      if (cmd_code == pmbus_pkg::CMD_OPERATION) begin
        op_ff <= {cmd_wdata[7], pmbus_pkg::OPERATION_RST[6],
                  cmd_wdata[5:4], pmbus_pkg::OPERATION_RST[3:0]};
      end
      if (cmd_code == pmbus_pkg::CMD_ON_OFF_CONFIG) begin
        onoff_ff <= {pmbus_pkg::ON_OFF_RST[7:3], cmd_wdata[2],
                     pmbus_pkg::ON_OFF_RST[1:0]};
      end
    end
  end

  // Settings; a rejected write leaves the old value in place
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vset_ff <= pmbus_pkg::VOUT_SET_RST;
      mhi_ff <= pmbus_pkg::MARGIN_HIGH_RST;
      mlo_ff <= pmbus_pkg::MARGIN_LOW_RST;
      von_ff <= pmbus_pkg::VIN_ON_RST;
      voff_ff <= pmbus_pkg::VIN_OFF_RST;
      tdly_ff <= pmbus_pkg::TON_DELAY_RST;
      trise_ff <= pmbus_pkg::TON_RISE_RST;
    end else if (wr_take) begin
      unique case (cmd_code)
        pmbus_pkg::CMD_VOUT_SETPOINT: vset_ff <= cmd_wdata;
        pmbus_pkg::CMD_MARGIN_HIGH: mhi_ff <= cmd_wdata;
        pmbus_pkg::CMD_MARGIN_LOW: mlo_ff <= cmd_wdata;
        pmbus_pkg::CMD_VIN_ON: von_ff <= cmd_wdata;
        pmbus_pkg::CMD_VIN_OFF: voff_ff <= cmd_wdata;
        pmbus_pkg::CMD_TON_DELAY: tdly_ff <= cmd_wdata;
        pmbus_pkg::CMD_TON_RISE: trise_ff <= cmd_wdata;
        default: begin
        end
      endcase
    end
  end

  // Storage sees a one-cycle strobe only on the store command
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      store_ff <= 1'b0;
    end else begin
      store_ff <= wr_take &&
                  (cmd_code == pmbus_pkg::CMD_STORE_ALL);
    end
  end

  // Margin decode; bits 3:2 are fixed so only three codes can occur
  always_comb begin
    casez (op_ff[5:2])
      4'b00??: margin_sel = pmbus_pkg::MARGIN_OFF;
      4'b0110: margin_sel = pmbus_pkg::MARGIN_LO;
      4'b1010: margin_sel = pmbus_pkg::MARGIN_HI;
      default: margin_sel = pmbus_pkg::MARGIN_OFF;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vtgt_ff <= pmbus_pkg::VOUT_SET_RST;
    end else begin
      unique case (margin_sel)
        pmbus_pkg::MARGIN_LO: vtgt_ff <= mlo_ff;
        pmbus_pkg::MARGIN_HI: vtgt_ff <= mhi_ff;
        pmbus_pkg::MARGIN_OFF: vtgt_ff <= vset_ff;
      endcase
    end
  end

  // Pin filter: a change counts once stages two and three agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      pin_ff <= '0;
    end else begin
      s1_ff <= {power_good_pin, temp_fault_pin, vin_uv_pin,
                iout_warn_pin, iout_oc_pin, vout_ov_pin};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= (s2_ff & s3_ff) | (pin_ff & (s2_ff ^ s3_ff));
    end
  end

  // Latched flags; a new fault in the clearing cycle still sets
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ov_ff <= 1'b0;
      oc_ff <= 1'b0;
      warn_ff <= 1'b0;
      uv_ff <= 1'b0;
      temp_ff <= 1'b0;
    end else begin
      ov_ff <= pin_ff[pmbus_pkg::PIN_OV] || (ov_ff && !clr);
      oc_ff <= pin_ff[pmbus_pkg::PIN_OC] || (oc_ff && !clr);
      warn_ff <= pin_ff[pmbus_pkg::PIN_WARN] || (warn_ff && !clr);
      uv_ff <= pin_ff[pmbus_pkg::PIN_UV] || (uv_ff && !clr);
      temp_ff <= pin_ff[pmbus_pkg::PIN_TEMP] || (temp_ff && !clr);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cml_cmd_ff <= 1'b0;
      cml_data_ff <= 1'b0;
    end else begin
      cml_cmd_ff <= bad_cmd || (cml_cmd_ff && !clr);
      cml_data_ff <= bad_data || (cml_data_ff && !clr);
    end
  end

  // Output voltage readback, saturated to the unsigned range
  assign vout_sum = $signed({2'b00, vout_adc}) +
                    $signed({{2{vout_readback_offset[15]}},
                             vout_readback_offset});

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vout_rd_ff <= 16'h0000;
    end else if (vout_sum < 18'sd0) begin
      vout_rd_ff <= 16'h0000;
    end else if (vout_sum > 18'sd65535) begin
      vout_rd_ff <= 16'hffff;
    end else begin
      vout_rd_ff <= vout_sum[15:0];
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 16'h0000;
    end else begin
      rsp_valid_ff <= cmd_valid && !cmd_write && rd_known;
      if (cmd_valid && !cmd_write && rd_known) begin
        rsp_data_ff <= rd_word;
      end
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign output_enable = op_ff[pmbus_pkg::OP_ON];
  assign vout_target = vtgt_ff;
  assign vout_setpoint = vset_ff;
  assign margin_high = mhi_ff;
  assign margin_low = mlo_ff;
  assign vin_on = von_ff;
  assign vin_off = voff_ff;
  assign ton_delay = tdly_ff;
  assign ton_rise = trise_ff;
  assign store_all = store_ff;
endmodule : pmbus_telemetry_status
`default_nettype wire

// >>> testbench/host_model.sv
// Host side of the decoded command port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data
);
  initial begin
    cmd_valid = 0;
    cmd_write = 0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // Words go out whole with the exponent field as given
  task wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    cmd_valid <= 1;
    cmd_write <= 1;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 0;
  endtask : wr
  // Answer is a one-cycle pulse, so it is caught just after the taking edge
  task rd(input logic [7:0] c, output logic [16:0] r);
    @(posedge clk);
    cmd_valid <= 1;
    cmd_write <= 0;
    cmd_code <= c;
    @(posedge clk);
    cmd_valid <= 0;
    #1 r = {rsp_valid, rsp_data};
  endtask : rd
endmodule : host_model
`default_nettype wire

// >>> testbench/telemetry_assertions.sv
// Port assertions of the telemetry and status block
`timescale 1ns/1ps
`default_nettype none
module telemetry_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  // Settings
  input wire logic output_enable,
  input wire logic [15:0] vout_setpoint,
  input wire logic [15:0] vin_on,
  input wire logic [15:0] ton_delay,
  input wire logic store_all
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wr_ok;
  assign wr_ok = cmd_valid && cmd_write;
  a_status_answer: assert property (
    cmd_valid && !cmd_write && cmd_code == 8'h79 |=> rsp_valid)
    else $error("status read not answered");
  a_unknown_silent: assert property (
    cmd_valid && cmd_code == 8'hff |=> !rsp_valid)
    else $error("unknown code answered");
  a_enable_bit: assert property (
    wr_ok && cmd_code == 8'h01 && cmd_wdata[5:4] != 2'b11
    |=> output_enable == $past(cmd_wdata[7]))
    else $error("enable not taken from bit 7");
  a_setpoint_keep: assert property (
    wr_ok && cmd_code == 8'h21 && cmd_wdata > 16'hd333
    |=> $stable(vout_setpoint))
    else $error("setpoint above range taken");
  a_setpoint_cause: assert property (
    $changed(vout_setpoint) |-> $past(wr_ok && cmd_code == 8'h21))
    else $error("setpoint changed without write");
  a_store_pulse: assert property (
    wr_ok && cmd_code == 8'h11 |=> store_all ##1 !store_all)
    else $error("store pulse missing");
  a_store_cause: assert property (
    store_all |-> $past(wr_ok && cmd_code == 8'h11))
    else $error("store without command");
  a_delay_floor: assert property (
    wr_ok && cmd_code == 8'h60 && cmd_wdata[10:0] < 11'h014
    |=> $stable(ton_delay))
    else $error("delay below floor taken");
  a_format_fixed: assert property (
    vin_on[15:11] == 5'h1d && ton_delay[15:11] == 5'h1f)
    else $error("fixed exponent lost");
  c_store: cover property (store_all);
  c_enable_off: cover property ($fell(output_enable));
  c_answer: cover property (rsp_valid);
endmodule : telemetry_assertions
bind pmbus_telemetry_status telemetry_assertions chk_i (.clk, .sys_rst,
  .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .rsp_valid,
  .output_enable, .vout_setpoint, .vin_on, .ton_delay, .store_all);
`default_nettype wire

// >>> testbench/pmbus_telemetry_status_bench.sv
// Command-level bench of the telemetry and status block
`timescale 1ns/1ps
`default_nettype none
module pmbus_telemetry_status_bench;
  logic clk = 0, sys_rst = 1, cmd_valid, cmd_write, rsp_valid, store_all;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_data, vout_adc = 16'hb000;
  logic [15:0] vout_readback_offset = 16'hfff0, vin_readback_offset = 16'h8;
  logic [15:0] vin_readback_gain = 16'h2000, current_readback_gain = 16'h4000;
  logic [15:0] current_readback_offset = 16'h07ff;
  logic [10:0] vin_adc = 11'h140, iout_adc = 11'h100, temp_adc = 11'h7f6;
  logic iout_sinking = 0, vout_ov_pin = 0, iout_oc_pin = 0, iout_warn_pin = 0;
  logic vin_uv_pin = 0, temp_fault_pin = 0, power_good_pin = 1, output_enable;
  logic [15:0] vout_target, vout_setpoint, margin_high, margin_low;
  logic [15:0] vin_on, vin_off, ton_delay, ton_rise;
  logic [16:0] r;
  int bad_count = 0, num_checks = 0;
  logic [15:0] ops [4] = '{16'h98, 16'ha8, 16'h88, 16'h08};
  logic [16:0] tgt [4] = '{17'h1b666, 17'h1c99a, 17'h1d333, 17'h0d333};
  host_model h (.clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
    .rsp_valid, .rsp_data);
  pmbus_telemetry_status uut (.clk, .sys_rst, .cmd_valid, .cmd_write,
    .cmd_code, .cmd_wdata, .rsp_valid, .rsp_data, .vout_adc, .vin_adc,
    .iout_adc, .iout_sinking, .temp_adc, .vout_readback_offset,
    .vin_readback_offset, .vin_readback_gain, .current_readback_offset,
    .current_readback_gain, .vout_ov_pin, .iout_oc_pin, .iout_warn_pin,
    .vin_uv_pin, .temp_fault_pin, .power_good_pin, .output_enable,
    .vout_target, .vout_setpoint, .margin_high, .margin_low, .vin_on,
    .vin_off, .ton_delay, .ton_rise, .store_all);
  always #2.5 clk = ~clk;
  task chk(input logic [16:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task rc(input logic [7:0] c, input logic [16:0] e);
    h.rd(c, r);
    chk(r, e);
  endtask : rc
  // Pins are held well past the synchroniser and filter depth
  task pins(input logic [5:0] v);
    @(posedge clk);
    {vout_ov_pin, iout_oc_pin, iout_warn_pin, vin_uv_pin, temp_fault_pin,
      power_good_pin} <= v;
    repeat (10) @(posedge clk);
  endtask : pins
  task end_sim;
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    pins(6'h01);
    rc(8'h79, 17'h10000);
    pins(6'h3e);
    rc(8'h79, 17'h1e83c);
    rc(8'h7a, 17'h10080);
    rc(8'h7b, 17'h100a0);
    pins(6'h01);
    rc(8'h79, 17'h1e03c);
    h.wr(8'h03, 16'h0);
    rc(8'h79, 17'h10000);
    h.wr(8'h21, 16'hd333);
    h.wr(8'h21, 16'hd334);
    @(posedge clk);
    #1 chk(vout_setpoint, 16'hd333);
    chk(vout_target, 16'hd333);
    rc(8'h7e, 17'h10040);
    rc(8'h79, 17'h10002);
    h.rd(8'hff, r);
    chk(r[16], 17'h00000);
    rc(8'h7e, 17'h100c0);
    h.wr(8'h03, 16'h0);
    h.wr(8'h60, 16'hfbe8);
    h.wr(8'h60, 16'hf813);
    h.wr(8'h61, 16'hfbe8);
    h.wr(8'h61, 16'hf81d);
    h.wr(8'h35, 16'he920);
    h.wr(8'h35, 16'hf120);
    @(posedge clk);
    #1 chk(ton_delay, 16'hfbe8);
    chk(ton_rise, 16'hfbe8);
    chk(vin_on, 16'he920);
    foreach (ops[i]) begin
      h.wr(8'h01, ops[i]);
      repeat (2) @(posedge clk);
      #1 chk({output_enable, vout_target}, tgt[i]);
    end
    rc(8'h79, 17'h10042);
    h.wr(8'h11, 16'h0);
    #1 chk(store_all, 17'h00001);
    @(posedge clk);
    #1 chk(store_all, 17'h00000);
    h.wr(8'h26, 16'hc000);
    h.wr(8'h25, 16'hc000);
    @(posedge clk);
    #1 chk(margin_low, 16'hc000);
    chk(margin_high, 16'hc99a);
    chk(vin_off, 16'he900);
    rc(8'h8b, 17'h1aff0);
    rc(8'hd0, 17'h1fff0);
    rc(8'h88, 17'h1e948);
    rc(8'h8c, 17'h1e1ff);
    rc(8'h8d, 17'h1f7f6);
    @(posedge clk);
    iout_sinking <= 1;
    repeat (2) @(posedge clk);
    rc(8'h8c, 17'h1e000);
    @(posedge clk);
    iout_sinking <= 0;
    iout_adc <= 11'h008;
    repeat (2) @(posedge clk);
    rc(8'h8c, 17'h1e000);
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_sim();
  end
endmodule : pmbus_telemetry_status_bench
`default_nettype wire
